// ---- lks_defines.vh ----
// Constants for the lookup, selector and math datapath
`ifndef LKS_DEFINES_VH
`define LKS_DEFINES_VH
`define LKS_NLUT      3
`define LKS_NPT       11
`define LKS_NOPD      5
`define LKS_NSTG      4
`define LKS_RSP_IGN   2'h0
`define LKS_RSP_RAMP  2'h1
`define LKS_RSP_JUMP  2'h2
`define LKS_XMIN      32'shFFFE7960
`define LKS_XMAX      32'sh000F4240
`define LKS_FULL      32'sh00002710
`define LKS_ONE       32'sh00000064
`define LKS_MS_NS     1000000
`define LKS_CLK_NS    10
`define LKS_MS_CYCLES (`LKS_MS_NS / `LKS_CLK_NS)
`define LKS_A_CTRL    10'h000
`define LKS_A_SELTAB  10'h004
`define LKS_A_CND0    10'h008
`define LKS_A_CND1    10'h00C
`define LKS_A_CND2    10'h010
`define LKS_A_MSRC    10'h020
`define LKS_A_OMIN    10'h090
`define LKS_A_OMAX    10'h094
`define LKS_A_SELOUT  10'h0B0
`define LKS_A_MOUT    10'h0B4
`define LKS_G_MSCL    6'h04
`define LKS_G_LCFG    6'h0A
`define LKS_G_LSTAT   6'h0C
`endif

// ---- lks_datapath.v ----
// Lookup tables, table selector and chained math block with Wishbone slave
// What this block does
// RL1: Tables give up to ten piecewise segments
// RL2: Axis mode picks source value or time
// RL3: Time mode x values are milliseconds enabled
// RL4: Ramp code interpolates between neighbour points
// RL5: Jump code outputs this point's y
// RL6: Point zero always jumps, writes ignored
// RL7: Ignore code drops this and later points
// RL8: X range limited to fixed bounds
// RL9: X points kept in non-decreasing order
// RL10: Output min, max from kept y values
// RL11: Selector inactive until enabled, reset false
// RL12: Selector outputs chosen table of three
// RL13: Three comparisons per table, six codes
// RL14: Unused argument source reads as zero
// RL15: Combining code merges three condition results
// RL16: First true table wins, else first
// RL17: Math inputs scaled to percent, decimals
// RL18: Stage results chain into next operand
// RL19: Unused second operand passes value through
// RL20: Fifteen math operator codes
// RL21: Boolean true from one percent, yields 0/1
// RL22: Zero divisor gives full scale
// RL23: Outputs update per strobe, reset clears
`timescale 1ns/10ps
`include "lks_defines.vh"
module lks_datapath #(
  parameter MS_CYCLES = `LKS_MS_CYCLES
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire         wb_cyc_i,
  input  wire         wb_stb_i,
  input  wire         wb_we_i,
  input  wire [9:0]   wb_adr_i,
  input  wire [3:0]   wb_sel_i,
  input  wire [31:0]  wb_dat_i,
  output reg  [31:0]  wb_dat_o,
  output reg          wb_ack_o,
  input  wire         eval_strobe,
  input  wire [127:0] src_vals,
  output wire [95:0]  lut_out_bus,
  output reg  [31:0]  sel_out,
  output reg  [31:0]  math_out
);
  localparam NT = `LKS_NLUT;
  localparam NP = `LKS_NPT;
  localparam NE = NT * NP;
  localparam [31:0] MS_LAST = MS_CYCLES - 1;

  reg               sel_en;
  reg  [5:0]        tab_num;
  reg  [8:0]        comb;
  reg  [29:0]       cnd   [0:NT-1];
  reg  [14:0]       msrc;
  reg  [15:0]       mops;
  reg  signed [31:0] mmin [0:`LKS_NOPD-1];
  reg  signed [31:0] mmax [0:`LKS_NOPD-1];
  reg  [1:0]        mdd   [0:`LKS_NOPD-1];
  reg  signed [31:0] omin;
  reg  signed [31:0] omax;
  reg  [3:0]        lcfg  [0:NT-1];
  reg  signed [31:0] lut_x [0:NE-1];
  reg  signed [31:0] lut_y [0:NE-1];
  reg  [1:0]        lut_r [0:NE-1];
  wire signed [31:0] src_w [0:7];
  wire signed [31:0] lo_w  [0:NT-1];
  wire signed [31:0] mn_w  [0:NT-1];
  wire signed [31:0] mx_w  [0:NT-1];
  wire [31:0]       tm_w  [0:NT-1];
  wire signed [31:0] pct_w [0:`LKS_NOPD-1];
  wire [NT-1:0]     hit;
  integer           n;
  genvar            g;
  genvar            k;

  function cmp;
    input [2:0]        op;
    input signed [31:0] a;
    input signed [31:0] b;
    begin
      case (op) // RL13
        3'h0: cmp = (a == b);
        3'h1: cmp = (a != b);
        3'h2: cmp = (a > b);
        3'h3: cmp = (a >= b);
        3'h4: cmp = (a < b);
        3'h5: cmp = (a <= b);
        default: cmp = 1'b0;
      endcase
    end
  endfunction

  function signed [31:0] p10;
    input [1:0] d;
    begin
      case (d)
        2'h0: p10 = 32'sh00000001;
        2'h1: p10 = 32'sh0000000A;
        2'h2: p10 = 32'sh00000064;
        default: p10 = 32'sh000003E8;
      endcase
    end
  endfunction

  function signed [31:0] alu;
    input [3:0]        op;
    input signed [31:0] a;
    input signed [31:0] b;
    reg signed [63:0]  r;
    reg                ta;
    reg                tb;
    begin
      ta = (a >= `LKS_ONE); // RL21
      tb = (b >= `LKS_ONE); // RL21
      r = 64'sh0;
      case (op) // RL20
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
          r = cmp(op[2:0], a, b) ? `LKS_ONE : 32'sh0; // RL21
        4'h6: r = (ta | tb) ? `LKS_ONE : 32'sh0;
        4'h7: r = (ta & tb) ? `LKS_ONE : 32'sh0;
        4'h8: r = (ta ^ tb) ? `LKS_ONE : 32'sh0;
        4'h9: r = a + b;
        4'hA: r = a - b;
        4'hB: r = (a * b) / `LKS_FULL;
        4'hC: begin
          if (b == 32'sh0) begin
            r = `LKS_FULL; // RL22
          end else begin
            r = (a * `LKS_FULL) / b;
          end
        end
        4'hD: r = (a < b) ? a : b;
        4'hE: r = (a > b) ? a : b;
        default: r = 64'sh0;
      endcase
      if (op >= 4'h9 && r > `LKS_FULL) begin
        r = `LKS_FULL;
      end
      if (op >= 4'h9 && r < 0) begin
        r = 64'sh0;
      end
      alu = r[31:0];
    end
  endfunction

  // Source codes: 0 unused, 1..4 external, 5..7 table outputs
  assign src_w[0] = 32'sh0; // RL14
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ext
      assign src_w[g+1] = src_vals[g*32 +: 32];
    end
  endgenerate

  // Lookup tables with millisecond timers
  generate
    for (g = 0; g < NT; g = g + 1) begin : g_lut
      reg  signed [31:0] xin;
      reg  signed [31:0] yo;
      reg  signed [31:0] ymn;
      reg  signed [31:0] ymx;
      reg  signed [31:0] xp;
      reg  signed [31:0] yp;
      reg  signed [31:0] xi;
      reg  signed [31:0] yi;
      reg  signed [63:0] num;
      reg  signed [63:0] den;
      reg                alive;
      reg                done;
      reg  [31:0]        tms;
      reg  [31:0]        pre;
      reg  signed [31:0] lo;
      reg  signed [31:0] mn;
      reg  signed [31:0] mx;
      integer            i;
      wire signed [31:0] sv = src_w[lcfg[g][3:1]];
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          tms <= 32'h0;
          pre <= 32'h0;
        end else if (sv == 32'sh0) begin
          tms <= 32'h0; // RL3
          pre <= 32'h0;
        end else if (pre == MS_LAST) begin
          pre <= 32'h0;
          if (tms != `LKS_XMAX) begin
            tms <= tms + 32'h1; // RL3
          end
        end else begin
          pre <= pre + 32'h1;
        end
      end
      always @* begin
        i = 0;
        xin = lcfg[g][0] ? tms : sv; // RL2
        if (xin < `LKS_XMIN) xin = `LKS_XMIN; // RL8
        if (xin > `LKS_XMAX) xin = `LKS_XMAX; // RL8
        yo = lut_y[g*NP];
        ymn = yo;
        ymx = yo;
        alive = 1'b1;
        done = (xin <= lut_x[g*NP]); // RL6
        xp = 32'sh0;
        yp = 32'sh0;
        xi = 32'sh0;
        yi = 32'sh0;
        num = 64'sh0;
        den = 64'sh0;
        for (i = 1; i < NP; i = i + 1) begin // RL1
          xp = lut_x[g*NP+i-1];
          yp = lut_y[g*NP+i-1];
          xi = lut_x[g*NP+i];
          yi = lut_y[g*NP+i];
          if (lut_r[g*NP+i] == `LKS_RSP_IGN) alive = 1'b0; // RL7
          if (alive) begin
            if (yi < ymn) ymn = yi; // RL10
            if (yi > ymx) ymx = yi; // RL10
            if (!done) begin
              yo = yi; // RL5
              if (xin <= xi) begin
                done = 1'b1;
                if (lut_r[g*NP+i] == `LKS_RSP_RAMP && xi != xp) begin
                  num = (xin - xp) * (yi - yp); // RL4
                  den = xi - xp;
                  num = num / den;
                  yo = yp + num[31:0]; // RL4
                end
              end
            end
          end
        end
      end
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          lo <= 32'sh0;
          mn <= 32'sh0;
          mx <= 32'sh0;
        end else if (eval_strobe) begin
          lo <= yo; // RL23
          mn <= ymn;
          mx <= ymx;
        end
      end
      assign lut_out_bus[g*32 +: 32] = lo;
      assign src_w[g+5] = lo;
      assign lo_w[g] = lo;
      assign mn_w[g] = mn;
      assign mx_w[g] = mx;
      assign tm_w[g] = tms;
    end
  endgenerate

  // Selector conditions per referenced table
  generate
    for (g = 0; g < NT; g = g + 1) begin : g_sel
      wire [2:0] cres;
      wire [2:0] cc = comb[g*3 +: 3];
      for (k = 0; k < 3; k = k + 1) begin : g_cnd
        assign cres[k] = cmp(cnd[g][k*10 +: 3],
                             src_w[cnd[g][k*10+3 +: 3]],
                             src_w[cnd[g][k*10+6 +: 3]]); // RL13
      end
      assign hit[g] = (cc == 3'h0) ? 1'b1 :
                      (cc == 3'h1) ? &cres :
                      (cc == 3'h2) ? |cres :
                      (cc == 3'h3) ? ((cres[0] & cres[1]) | cres[2]) :
                      (cc == 3'h4) ? ((cres[0] | cres[1]) & cres[2]) :
                      1'b0; // RL15
    end
  endgenerate

  wire [1:0] pick = hit[0] ? 2'h0 : hit[1] ? 2'h1 :
                    hit[2] ? 2'h2 : 2'h0; // RL16
  wire [1:0] tsel = tab_num[pick*2 +: 2]; // RL12
  wire signed [31:0] selv = (tsel < NT) ? lo_w[tsel] : 32'sh0;

  // Math operand scaling to percent
  generate
    for (g = 0; g < `LKS_NOPD; g = g + 1) begin : g_opd
      reg signed [63:0] sc;
      reg signed [63:0] rng;
      reg signed [31:0] pct;
      wire signed [31:0] v = src_w[msrc[g*3 +: 3]];
      always @* begin
        sc = v * p10(mdd[g]); // RL17
        sc = sc - mmin[g];
        rng = mmax[g] - mmin[g];
        if (rng <= 0) begin
          sc = 64'sh0;
        end else begin
          sc = (sc * `LKS_FULL) / rng; // RL17
        end
        if (sc < 0) sc = 64'sh0;
        if (sc > `LKS_FULL) sc = `LKS_FULL;
        pct = sc[31:0];
      end
      assign pct_w[g] = pct;
    end
  endgenerate

  reg signed [31:0] acc;
  reg signed [63:0] mres;
  integer           s;
  always @* begin
    acc = pct_w[0];
    for (s = 0; s < `LKS_NSTG; s = s + 1) begin
      if (msrc[(s+1)*3 +: 3] != 3'h0) begin // RL19
        acc = alu(mops[s*4 +: 4], acc, pct_w[s+1]); // RL18
      end
    end
    mres = (acc * (omax - omin)) / `LKS_FULL;
    mres = mres + omin;
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_out <= 32'h0;
      math_out <= 32'h0;
    end else if (eval_strobe) begin
      sel_out <= sel_en ? selv : 32'h0; // RL11
      math_out <= mres[31:0]; // RL23
    end
  end

  // Wishbone decode
  wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        bus_wr  = bus_req & wb_we_i;
  wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [1:0]  pt_t    = wb_adr_i[9:8] - 2'h1;
  wire [3:0]  pt_i    = wb_adr_i[7:4];
  wire [1:0]  fld     = wb_adr_i[3:2];
  wire [5:0]  grp     = wb_adr_i[9:4];
  wire        pt_hit  = (wb_adr_i[9:8] != 2'h0) && (pt_t < NT) &&
                        (pt_i < NP) && (fld != 2'h3);
  wire [5:0]  pt_p    = pt_t * 6'h0B + {2'h0, pt_i};
  wire [2:0]  ms_k    = grp[2:0] - 3'h4;
  wire        ms_hit  = (grp >= `LKS_G_MSCL) &&
                        (grp < `LKS_G_MSCL + `LKS_NOPD) && (fld != 2'h3);
  wire        lc_hit  = (grp == `LKS_G_LCFG) && (fld < NT);
  wire [1:0]  st_t    = grp[1:0];
  wire        st_hit  = (grp >= `LKS_G_LSTAT) && (grp < `LKS_G_LSTAT + NT);
  reg  [31:0] rd_val;
  reg  [31:0] wword;
  reg  signed [31:0] xnew;

  always @* begin
    rd_val = 32'h0;
    if (pt_hit) begin
      case (fld)
        2'h0: rd_val = lut_x[pt_p];
        2'h1: rd_val = lut_y[pt_p];
        default: rd_val = {30'h0, lut_r[pt_p]};
      endcase
    end else if (ms_hit) begin
      case (fld)
        2'h0: rd_val = mmin[ms_k];
        2'h1: rd_val = mmax[ms_k];
        default: rd_val = {30'h0, mdd[ms_k]};
      endcase
    end else if (lc_hit) begin
      rd_val = {28'h0, lcfg[fld]};
    end else if (st_hit) begin
      case (fld)
        2'h0: rd_val = lo_w[st_t];
        2'h1: rd_val = mn_w[st_t];
        2'h2: rd_val = mx_w[st_t];
        default: rd_val = tm_w[st_t];
      endcase
    end else begin
      case (wb_adr_i)
        `LKS_A_CTRL:   rd_val = {31'h0, sel_en};
        `LKS_A_SELTAB: rd_val = {15'h0, comb, 2'h0, tab_num};
        `LKS_A_CND0:   rd_val = {2'h0, cnd[0]};
        `LKS_A_CND1:   rd_val = {2'h0, cnd[1]};
        `LKS_A_CND2:   rd_val = {2'h0, cnd[2]};
        `LKS_A_MSRC:   rd_val = {mops, 1'b0, msrc};
        `LKS_A_OMIN:   rd_val = omin;
        `LKS_A_OMAX:   rd_val = omax;
        `LKS_A_SELOUT: rd_val = sel_out;
        `LKS_A_MOUT:   rd_val = math_out;
        default:       rd_val = 32'h0;
      endcase
    end
    wword = (rd_val & ~wmask) | (wb_dat_i & wmask);
    xnew = wword;
    if (xnew < `LKS_XMIN) xnew = `LKS_XMIN; // RL8
    if (xnew > `LKS_XMAX) xnew = `LKS_XMAX; // RL8
    if (pt_i != 4'h0 && xnew < lut_x[pt_p-6'h01]) begin
      xnew = lut_x[pt_p-6'h01]; // RL9
    end
    if (pt_i != NP - 1 && xnew > lut_x[pt_p+6'h01]) begin
      xnew = lut_x[pt_p+6'h01]; // RL9
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      sel_en <= 1'b0; // RL11
      tab_num <= 6'h0;
      comb <= 9'h0;
      msrc <= 15'h0;
      mops <= 16'h0;
      omin <= 32'sh0;
      omax <= `LKS_FULL;
      for (n = 0; n < NT; n = n + 1) begin
        cnd[n] <= 30'h0;
        lcfg[n] <= 4'h0;
      end
      for (n = 0; n < `LKS_NOPD; n = n + 1) begin
        mmin[n] <= 32'sh0;
        mmax[n] <= `LKS_FULL;
        mdd[n] <= 2'h0;
      end
      for (n = 0; n < NE; n = n + 1) begin
        lut_x[n] <= 32'sh0;
        lut_y[n] <= 32'sh0;
        lut_r[n] <= (n % NP == 0) ? `LKS_RSP_JUMP : `LKS_RSP_IGN;
      end
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= rd_val;
      end
      if (bus_wr) begin
        if (pt_hit) begin
          case (fld)
            2'h0: lut_x[pt_p] <= xnew; // RL9
            2'h1: lut_y[pt_p] <= wword;
            default: begin
              if (pt_i != 4'h0) begin
                lut_r[pt_p] <= wword[1:0]; // RL6
              end
            end
          endcase
        end else if (ms_hit) begin
          case (fld)
            2'h0: mmin[ms_k] <= wword;
            2'h1: mmax[ms_k] <= wword;
            default: mdd[ms_k] <= wword[1:0];
          endcase
        end else if (lc_hit) begin
          lcfg[fld] <= wword[3:0];
        end else begin
          case (wb_adr_i)
            `LKS_A_CTRL:   sel_en <= wword[0];
            `LKS_A_SELTAB: begin
              tab_num <= wword[5:0];
              comb <= wword[16:8];
            end
            `LKS_A_CND0:   cnd[0] <= wword[29:0];
            `LKS_A_CND1:   cnd[1] <= wword[29:0];
            `LKS_A_CND2:   cnd[2] <= wword[29:0];
            `LKS_A_MSRC: begin
              msrc <= wword[14:0];
              mops <= wword[31:16];
            end
            `LKS_A_OMIN:   omin <= wword;
            `LKS_A_OMAX:   omax <= wword;
            default: begin
            end
          endcase
        end
      end
    end
  end
endmodule // lks_datapath

// ---- lks_src_model.sv ----
// Source block model that issues evaluation strobes
`timescale 1ns/10ps
module lks_src_model (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       go,
  input  wire [3:0] dly,
  output reg        eval_strobe,
  output reg        done
);
  reg       busy;
  reg [3:0] cnt;
  // Strobe after a chosen delay, done one cycle later
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      eval_strobe <= 1'b0;
      done <= 1'b0;
    end else begin
      eval_strobe <= 1'b0;
      done <= eval_strobe;
      if (go && !busy) begin
        busy <= 1'b1;
        cnt <= dly;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        eval_strobe <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // lks_src_model

// ---- lks_datapath_asserts.sv ----
// Port checks for the lookup, selector and math datapath
`timescale 1ns/10ps
module lks_datapath_asserts #(
  parameter MS_CYCLES = 4
) (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [9:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        eval_strobe,
  input wire [95:0] lut_out_bus,
  input wire [31:0] sel_out,
  input wire [31:0] math_out
);
  reg  sel_en;
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Selector enable as last written
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      sel_en <= 1'b0;
    else if (take && wb_we_i && wb_adr_i[9:2] == 8'h00 && wb_sel_i[0])
      sel_en <= wb_dat_i[0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    take;
  endsequence
  sequence s_one_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_rd(w);
    take && !wb_we_i && wb_adr_i[9:2] == w && !eval_strobe;
  endsequence
  a_ack_latency: assert property (s_take |=> s_one_ack)
    else $error("bus answer not a single cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(take))
    else $error("bus answer without request");
  a_unmapped_zero: assert property (s_rd(8'h06) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_selout_read: assert property (
    s_rd(8'h2C) |=> wb_dat_o == sel_out)
    else $error("selector register differs from port");
  a_mathout_read: assert property (
    s_rd(8'h2D) |=> wb_dat_o == math_out)
    else $error("math register differs from port");
  a_lut_hold: assert property (
    !eval_strobe |=> $stable(lut_out_bus))
    else $error("table output moved without strobe");
  a_sel_hold: assert property (!eval_strobe |=> $stable(sel_out))
    else $error("selector output moved without strobe");
  a_math_hold: assert property (
    !eval_strobe |=> $stable(math_out))
    else $error("math output moved without strobe");
  a_sel_off: assert property (
    eval_strobe && !sel_en |=> sel_out == 32'h0)
    else $error("disabled selector output not zero");
endmodule // lks_datapath_asserts

// ---- tb_lks_datapath.sv ----
// Testbench for the lookup, selector and math datapath
`timescale 1ns/10ps
`include "lks_defines.vh"
module tb_lks_datapath;
  reg          ref_clk = 1'b0;
  reg          rst_n = 1'b0;
  reg          cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
  reg  [3:0]   sel = 4'hF, dly = 4'h0, msk = 4'hF;
  reg  [9:0]   adr = 10'h000;
  reg  [31:0]  dat = 32'h0, q;
  reg  [127:0] src = 128'h0;
  wire [31:0]  dat_o, sel_out, math_out;
  wire [95:0]  lut_out;
  wire         ack, strb, done;
  integer      miscompares = 0, comparisons = 0, cycles = 0, i, j;
  always #5 ref_clk = ~ref_clk;
  lks_datapath #(.MS_CYCLES(4)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .eval_strobe(strb), .src_vals(src), .lut_out_bus(lut_out),
    .sel_out(sel_out), .math_out(math_out));
  lks_src_model src_u (.ref_clk(ref_clk), .rst_n(rst_n), .go(go),
    .dly(dly), .eval_strobe(strb), .done(done));
  task finish_test;
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles > 20000) begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("ERROR %0s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task xfer(input w, input [9:0] a, input [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= msk;
    @(posedge ref_clk);
    while (ack !== 1'b1) @(posedge ref_clk);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input [9:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdchk(input string nm, input [9:0] a, input [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task strobe;
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    while (done !== 1'b1) @(posedge ref_clk);
  endtask
  function [9:0] pa(input integer t, input integer n);
    pa = (t + 1) * 256 + n * 16;
  endfunction
  function integer sat(input integer v);
    sat = v < 0 ? 0 : (v > 10000 ? 10000 : v);
  endfunction
  function cmp(input [3:0] op, input integer a, input integer b);
    cmp = op == 0 ? a == b : op == 1 ? a != b : op == 2 ? a > b :
          op == 3 ? a >= b : op == 4 ? a < b : a <= b;
  endfunction
  function integer mop(input [3:0] op, input integer a, input integer b);
    case (op)
      6: mop = (a >= 100 || b >= 100) ? 100 : 0;
      7: mop = (a >= 100 && b >= 100) ? 100 : 0;
      8: mop = ((a >= 100) != (b >= 100)) ? 100 : 0;
      9: mop = sat(a + b);
      10: mop = sat(a - b);
      11: mop = sat(a * b / 10000);
      12: mop = b == 0 ? 10000 : sat(a * 10000 / b);
      13: mop = a < b ? a : b;
      14: mop = a > b ? a : b;
      default: mop = cmp(op, a, b) ? 100 : 0;
    endcase
  endfunction
  function comb(input [2:0] c, input c0, input c1, input c2);
    comb = c == 0 ? 1'b1 : c == 1 ? c0 & c1 & c2 : c == 2 ? c0 | c1 | c2 :
           c == 3 ? (c0 & c1) | c2 : c == 4 ? (c0 | c1) & c2 : 1'b0;
  endfunction
  task lcase(input [31:0] v, input [31:0] e);
    src[31:0] <= v;
    strobe;
    chk("lut0", e, lut_out[31:0]);
  endtask
  task mcase(input [31:0] ms, input integer a, input integer b,
             input integer e);
    wr(`LKS_A_MSRC, ms);
    src[95:64] <= a;
    src[127:96] <= b;
    strobe;
    chk("math", e, math_out);
  endtask
  task t_reset;
    chk("lut0", 32'h0, lut_out[31:0]);
    rdchk("omax", `LKS_A_OMAX, 32'h2710);
    wr(pa(0, 0) + 8, 32'h1);
    rdchk("p0rsp", pa(0, 0) + 8, 32'h2);
    rdchk("unmap", 10'h018, 32'h0);
  endtask
  task t_table;
    for (i = 10; i > 0; i = i - 1) wr(pa(0, i), i == 1 ? 32'h64 : 32'hC8);
    wr(pa(0, 0) + 4, -32'hC8);
    wr(pa(0, 1) + 4, 32'h3E8);
    wr(pa(0, 2) + 4, 32'h5DC);
    wr(pa(0, 1) + 8, 32'h1);
    wr(pa(0, 2) + 8, 32'h2);
    wr(10'h0A0, 32'h2);
    wr(pa(0, 1), 32'h12C);
    rdchk("xord", pa(0, 1), 32'hC8);
    wr(pa(0, 1), 32'h64);
    wr(pa(0, 10), 32'h1E8480);
    rdchk("xmax", pa(0, 10), 32'hF4240);
    wr(pa(0, 0), -32'h30D40);
    rdchk("xmin", pa(0, 0), 32'hFFFE7960);
    wr(pa(0, 0), 32'h0);
    lcase(-32'h5, -32'hC8);
    lcase(32'h32, 32'h190);
    lcase(32'h64, 32'h3E8);
    lcase(32'h96, 32'h5DC);
    lcase(32'hFA, 32'h5DC);
    rdchk("ymin", 10'h0C4, -32'hC8);
    rdchk("ymax", 10'h0C8, 32'h5DC);
    wr(pa(0, 2) + 8, 32'h0);
    wr(pa(2, 0) + 4, 32'h77);
    lcase(32'h96, 32'h3E8);
    chk("lut2", 32'h77, lut_out[95:64]);
    rdchk("ymax", 10'h0C8, 32'h3E8);
  endtask
  task t_time;
    for (i = 10; i > 0; i = i - 1) wr(pa(1, i), 32'h3);
    wr(pa(1, 1) + 4, 32'h12C);
    wr(pa(1, 1) + 8, 32'h1);
    wr(10'h0A4, 32'h5);
    strobe;
    chk("lut1", 32'h0, lut_out[63:32]);
    src[63:32] <= 32'h1;
    repeat (40) @(posedge ref_clk);
    strobe;
    chk("lut1", 32'h12C, lut_out[63:32]);
    src[63:32] <= 32'h0;
    strobe;
    strobe;
    chk("lut1", 32'h0, lut_out[63:32]);
  endtask
  task t_select;
    src[31:0] <= 32'h64;
    dly <= 4'h3;
    strobe;
    chk("sel", 32'h0, sel_out);
    dly <= 4'h0;
    wr(`LKS_A_CTRL, 32'h1);
    wr(`LKS_A_SELTAB, 32'h14124);
    for (i = 0; i < 6; i = i + 1) begin
      for (j = -1; j < 2; j = j + 1) begin
        wr(`LKS_A_CND0, 32'h18 | i);
        src[95:64] <= j;
        strobe;
        chk("cmp", cmp(i, j, 0) ? 32'h3E8 : 32'h0, sel_out);
      end
    end
    wr(`LKS_A_CND0, 32'h10001A);
    for (i = 0; i < 6; i = i + 1) begin
      for (j = -1; j < 2; j = j + 2) begin
        wr(`LKS_A_SELTAB, 32'h24 | (i << 8));
        src[95:64] <= j;
        strobe;
        chk("comb", comb(i, j > 0, 1, 0) ? 32'h3E8 : 32'h0, sel_out);
      end
    end
    wr(`LKS_A_SELTAB, 32'h16D24);
    strobe;
    chk("none", 32'h3E8, sel_out);
    wr(`LKS_A_SELTAB, 32'h521);
    strobe;
    rdchk("selreg", `LKS_A_SELOUT, 32'h3E8);
    wr(`LKS_A_CTRL, 32'h0);
    strobe;
    chk("sel", 32'h0, sel_out);
  endtask
  task t_math;
    for (i = 0; i < 15; i = i + 1)
      mcase(32'h23 | (i << 16), 3000, 2000, mop(i, 3000, 2000));
    mcase(32'h60023, 99, 0, 0);
    mcase(32'h60023, 100, 0, 100);
    mcase(32'hC0023, 3000, 0, 10000);
    mcase(32'hA90123, 3000, 2000, 3000);
    wr(10'h048, 32'h1);
    wr(`LKS_A_OMIN, 32'h3E8);
    wr(`LKS_A_OMAX, 32'hBB8);
    mcase(32'h90023, 300, 0, 1600);
    rdchk("mathreg", `LKS_A_MOUT, 32'h640);
    msk = 4'h1;
    wr(`LKS_A_OMIN, 32'hFFFFFF55);
    msk = 4'hF;
    rdchk("omin", `LKS_A_OMIN, 32'h355);
  endtask
  task t_rst2;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk("math", 32'h0, math_out);
    chk("lut0", 32'h0, lut_out[31:0]);
    rdchk("omin", `LKS_A_OMIN, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_table;
    t_time;
    t_select;
    t_math;
    t_rst2;
    finish_test;
  end
endmodule // tb_lks_datapath
bind lks_datapath lks_datapath_asserts #(.MS_CYCLES(MS_CYCLES)) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .eval_strobe(eval_strobe),
  .lut_out_bus(lut_out_bus), .sel_out(sel_out), .math_out(math_out));
